// >>> inc/hpsh_pkg.sv
/*
 Package of the host port status handshake block: register offsets,
 field positions, reset values and timing counts.
 Assumes a 125 MHz device clock and an Avalon-MM register bus.
*/
package hpsh_pkg;
  // ------------------------------------------------------------------
  // Avalon register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [4:0] OFS_RXWORD = 5'h00;
  localparam logic [4:0] OFS_TXWORD = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_IRQST = 5'h10;
  localparam logic [4:0] OFS_IRQMSK = 5'h14;
  localparam logic [4:0] OFS_HVEC = 5'h18;
  // Control register fields
  localparam int CTRL_FA = 0;
  localparam int CTRL_FB = 1;
  localparam int CTRL_HCACK = 2;
  // Status register fields
  localparam int ST_HTDA = 0;
  localparam int ST_HTDB = 1;
  localparam int ST_HC = 2;
  localparam int ST_RXF = 3;
  localparam int ST_TXE = 4;
  localparam int ST_TRANSMITTER_READY_FLAG = 5;
  localparam int ST_HOST_REQUEST_LINE = 6;
  localparam int ST_WORD = 7;
  // Interrupt events
  localparam int IRQ_WORD = 0;
  localparam int IRQ_HCMD = 1;
  localparam int IRQ_RXTAKEN = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // Host port addresses
  localparam logic [2:0] HA_CTRL = 3'h0;
  localparam logic [2:0] HA_STAT = 3'h2;
  localparam logic [2:0] HA_HVEC = 3'h3;
  localparam logic [2:0] HA_BHI = 3'h5;
  localparam logic [2:0] HA_BMID = 3'h6;
  localparam logic [2:0] HA_BLO = 3'h7;
  localparam logic [6:0] HVEC_RST = 7'h12;
  // Timing: receive byte settle before the receive full flag moves
  localparam int CLK_MHZ = 125;
  localparam int SETTLE_NS = 16;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
endpackage : hpsh_pkg

// >>> inc/hpsh_sync_if.sv
/*
 Interface carrying one bank of bits through the two-stage synchroniser.
 Assumes both ends run on the device clock.
*/
`timescale 1ns/1ps
interface hpsh_sync_if;
  logic [15:0] async;
  logic [15:0] synced;
  modport owner (output async, input synced);
  modport sync (input async, output synced);
endinterface : hpsh_sync_if

// >>> rtl/hpsh_sync.sv
/*
 Two flip-flop synchroniser, one per bit, for the host pins.
 Assumes each bit is independent; no bit is coherent with another.
*/
`timescale 1ns/1ps
module hpsh_sync (
  input wire logic clk,
  input wire logic arst_n,
  hpsh_sync_if.sync bus
);
  logic [15:0] stage1_r;
  logic [15:0] stage2_r;
  // ------------------------------------------------------------------
  // Per-bit double register
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_bit
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          stage1_r[gi] <= 1'b0;
          stage2_r[gi] <= 1'b0;
        end
        else
        begin
          stage1_r[gi] <= bus.async[gi];
          stage2_r[gi] <= stage1_r[gi];
        end
      end
    end
  endgenerate
  assign bus.synced = stage2_r;
endmodule : hpsh_sync

// >>> rtl/hpsh_host_port.sv
/*
 Device side of a byte-wide asynchronous host port with status flags.
 Assumes the host strobe, address, direction and data come from pins
 asynchronous to clk; registers reached over Avalon-MM with waitrequest.
*/
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module hpsh_host_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic host_enable_strobe_n,
  input wire logic host_rw,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic host_request_line
);
  typedef enum logic [1:0] {
    HPSH_IDLE = 2'b00,
    HPSH_ACC = 2'b01,
    HPSH_DONE = 2'b11
  } hpsh_state_t;

  hpsh_sync_if sif ();
  hpsh_state_t hst_r, hst_nxt;
  logic [7:0] rx_byte_high_r, rx_byte_middle_r, rx_byte_low_r;
  logic [7:0] tx_byte_high_r, tx_byte_middle_r, tx_byte_low_r;
  logic [23:0] internal_receive_word_r;
  logic [23:0] rxPend_r;
  logic receive_full_flag_r, transmit_empty_flag_r, wordValid_r;
  logic device_to_host_flag_a_r, device_to_host_flag_b_r;
  logic host_to_device_flag_a_r, host_to_device_flag_b_r;
  logic host_command_bit_r;
  logic [6:0] host_vector_field_r;
  logic [2:0] irqSt_r, irqMsk_r;
  logic [7:0] hostOut_r;
  logic [3:0] settle_r;
  logic ack_r, rxLoad_r;
  logic enS, rwS;
  logic [2:0] aS;
  logic [7:0] dS;
  // ------------------------------------------------------------------
  // Host pin synchronisation
  // ------------------------------------------------------------------
  assign sif.async = {host_data_in, 1'b0, host_addr, host_rw,
                      ~host_enable_strobe_n, 2'b00};
  hpsh_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .bus(sif.sync)
  );
  assign enS = sif.synced[2];
  assign rwS = sif.synced[3];
  assign aS = sif.synced[6:4];
  assign dS = sif.synced[15:8];
  // ------------------------------------------------------------------
  // Host access sequencer: one action per strobe
  // ------------------------------------------------------------------
  wire hostAct = (hst_r == HPSH_ACC);
  wire hostWr = hostAct && !rwS;
  wire hostRd = hostAct && rwS;
  always_comb
  begin
    case (hst_r)
      HPSH_IDLE: hst_nxt = enS ? HPSH_ACC : HPSH_IDLE;
      HPSH_ACC: hst_nxt = HPSH_DONE;
      HPSH_DONE: hst_nxt = enS ? HPSH_DONE : HPSH_IDLE;
      default: hst_nxt = HPSH_IDLE;
    endcase
  end
  // Host decode
  wire wrBlo = hostWr && (aS == hpsh_pkg::HA_BLO);
  wire wrByte = hostWr && (aS == hpsh_pkg::HA_BHI
                || aS == hpsh_pkg::HA_BMID || aS == hpsh_pkg::HA_BLO);
  wire wrCtl = hostWr && (aS == hpsh_pkg::HA_CTRL);
  wire wrVec = hostWr && (aS == hpsh_pkg::HA_HVEC);
  wire rdBlo = hostRd && (aS == hpsh_pkg::HA_BLO);
  // Byte write accepted only while empty
  wire txAccept = wrByte && transmit_empty_flag_r;
  // Vector change ignored while command pending
  wire vecAccept = wrVec && !host_command_bit_r;
  // ------------------------------------------------------------------
  // Avalon decode
  // ------------------------------------------------------------------
  wire busWr = avs_write && !avs_waitrequest;
  wire busRd = avs_read && !avs_waitrequest;
  wire wrTx = busWr && (avs_address == hpsh_pkg::OFS_TXWORD);
  wire wrCtrl = busWr && (avs_address == hpsh_pkg::OFS_CTRL);
  wire wrIrqSt = busWr && (avs_address == hpsh_pkg::OFS_IRQST);
  wire wrIrqMsk = busWr && (avs_address == hpsh_pkg::OFS_IRQMSK);
  wire rdRx = busRd && (avs_address == hpsh_pkg::OFS_RXWORD);
  wire hcAck = wrCtrl && avs_writedata[hpsh_pkg::CTRL_HCACK];
  // Receive bytes load only once empty and settled
  wire rxLoadReq = wrTx && !receive_full_flag_r && !rxLoad_r;
  wire txDone = txAccept && (aS == hpsh_pkg::HA_BLO);
  wire settled = (settle_r == 4'h0);
  wire [2:0] irqEv = {rdBlo && receive_full_flag_r,
                      wrCtl && sif.synced[8 + 7],
                      txDone};
  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  wire [7:0] statByte = {wordValid_r, host_request_line,
                         transmit_empty_flag_r, transmit_empty_flag_r,
                         receive_full_flag_r, host_command_bit_r,
                         device_to_host_flag_b_r,
                         device_to_host_flag_a_r};
  wire [31:0] busMux =
    (avs_address == hpsh_pkg::OFS_RXWORD) ? {8'h00, internal_receive_word_r} :
    (avs_address == hpsh_pkg::OFS_TXWORD) ? {8'h00, rxPend_r} :
    (avs_address == hpsh_pkg::OFS_CTRL) ?
      {30'h0, device_to_host_flag_b_r, device_to_host_flag_a_r} :
    (avs_address == hpsh_pkg::OFS_STAT) ?
      {24'h0, wordValid_r, host_request_line, transmit_empty_flag_r,
       receive_full_flag_r, 1'b0, host_command_bit_r,
       host_to_device_flag_b_r, host_to_device_flag_a_r} :
    (avs_address == hpsh_pkg::OFS_IRQST) ? {29'h0, irqSt_r} :
    (avs_address == hpsh_pkg::OFS_IRQMSK) ? {29'h0, irqMsk_r} :
    (avs_address == hpsh_pkg::OFS_HVEC) ? {25'h0, host_vector_field_r} :
    32'h0;
  wire [7:0] hostMux =
    (aS == hpsh_pkg::HA_STAT) ? statByte :
    (aS == hpsh_pkg::HA_CTRL) ?
      {5'h0, host_command_bit_r, host_to_device_flag_b_r,
       host_to_device_flag_a_r} :
    (aS == hpsh_pkg::HA_HVEC) ? {1'b0, host_vector_field_r} :
    (aS == hpsh_pkg::HA_BHI) ? rx_byte_high_r :
    (aS == hpsh_pkg::HA_BMID) ? rx_byte_middle_r :
    (aS == hpsh_pkg::HA_BLO) ? rx_byte_low_r : 8'h00;
  assign avs_waitrequest = !ack_r && (avs_read || avs_write);
  assign irq = |(irqSt_r & irqMsk_r);
  assign host_data_out = hostOut_r;
  assign host_data_oe = !host_enable_strobe_n && host_rw;
  assign host_request_line = receive_full_flag_r || transmit_empty_flag_r;
  // ------------------------------------------------------------------
  // Bus slave, one wait cycle per access
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (avs_read && !ack_r)
        avs_readdata <= busMux;
    end
  end
  // ------------------------------------------------------------------
  // Host state and data
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hst_r <= HPSH_IDLE;
      hostOut_r <= 8'h00;
      tx_byte_high_r <= 8'h00;
      tx_byte_middle_r <= 8'h00;
      tx_byte_low_r <= 8'h00;
      host_to_device_flag_a_r <= 1'b0;
      host_to_device_flag_b_r <= 1'b0;
      host_vector_field_r <= hpsh_pkg::HVEC_RST;
    end
    else
    begin
      hst_r <= hst_nxt;
      if (hostRd)
        hostOut_r <= hostMux;
      if (txAccept && aS == hpsh_pkg::HA_BHI)
        tx_byte_high_r <= dS;
      if (txAccept && aS == hpsh_pkg::HA_BMID)
        tx_byte_middle_r <= dS;
      if (txAccept && aS == hpsh_pkg::HA_BLO)
        tx_byte_low_r <= dS;
      if (wrCtl)
      begin
        host_to_device_flag_a_r <= dS[0];
        host_to_device_flag_b_r <= dS[1];
      end
      if (vecAccept)
        host_vector_field_r <= dS[6:0];
    end
  end
  // ------------------------------------------------------------------
  // Flags, command, transfer word, interrupts
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      receive_full_flag_r <= 1'b0;
      transmit_empty_flag_r <= 1'b1;
      wordValid_r <= 1'b0;
      host_command_bit_r <= 1'b0;
      internal_receive_word_r <= 24'h0;
      rxPend_r <= 24'h0;
      rx_byte_high_r <= 8'h00;
      rx_byte_middle_r <= 8'h00;
      rx_byte_low_r <= 8'h00;
      rxLoad_r <= 1'b0;
      settle_r <= 4'h0;
      device_to_host_flag_a_r <= 1'b0;
      device_to_host_flag_b_r <= 1'b0;
      irqSt_r <= hpsh_pkg::IRQ_RST;
      irqMsk_r <= hpsh_pkg::IRQ_RST;
    end
    else
    begin
      if (wrCtrl)
      begin
        // Both device flags move in one edge; host never sees old and new bits mixed
        device_to_host_flag_a_r <= avs_writedata[hpsh_pkg::CTRL_FA];
        device_to_host_flag_b_r <= avs_writedata[hpsh_pkg::CTRL_FB];
      end
      // Host sets or cancels; acknowledge clears; set wins
      if (wrCtl)
        host_command_bit_r <= dS[7];
      else if (hcAck)
        host_command_bit_r <= 1'b0;
      if (rxLoadReq)
      begin
        rx_byte_high_r <= avs_writedata[23:16];
        rx_byte_middle_r <= avs_writedata[15:8];
        rx_byte_low_r <= avs_writedata[7:0];
        rxPend_r <= avs_writedata[23:0];
        rxLoad_r <= 1'b1;
        settle_r <= 4'(hpsh_pkg::SETTLE_CYC);
      end
      else if (!settled)
        settle_r <= settle_r - 4'h1;
      else if (rxLoad_r)
      begin
        rxLoad_r <= 1'b0;
        receive_full_flag_r <= 1'b1;
      end
      else if (rdBlo)
        receive_full_flag_r <= 1'b0;
      // Transfer word into internal register
      if (txDone)
      begin
        internal_receive_word_r <= {tx_byte_high_r, tx_byte_middle_r, dS};
        transmit_empty_flag_r <= 1'b0;
        wordValid_r <= 1'b1;
      end
      else if (rdRx)
      begin
        wordValid_r <= 1'b0;
        transmit_empty_flag_r <= 1'b1;
      end
      irqMsk_r <= wrIrqMsk ? avs_writedata[2:0] : irqMsk_r;
      irqSt_r <= irqEv | (irqSt_r & ~(wrIrqSt ? avs_writedata[2:0] : 3'h0));
    end
  end
endmodule : hpsh_host_port

// >>> verif/hpsh_host_port_chk.sv
/*
 Port checker of the host port status handshake block.
 Assumes it is bound to hpsh_host_port and sees its ports only.
*/
`timescale 1ns/1ps
module hpsh_host_port_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic host_enable_strobe_n,
  input wire logic host_rw,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic host_request_line
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic wrTaken_r;
  // Write accepted at the previous edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wrTaken_r <= 1'b0;
    else
      wrTaken_r <= avs_write && !avs_waitrequest;
  end
  wait_once_a: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one");
  wait_first_a: assert property ((avs_read || avs_write) &&
    !avs_waitrequest |-> $past(avs_waitrequest)) else $error("no wait");
  read_oe_a: assert property (host_data_oe ==
    (!host_enable_strobe_n && host_rw)) else $error("oe mismatch");
  hold_out_a: assert property ((!host_enable_strobe_n && host_rw)[*8]
    |-> $stable(host_data_out)) else $error("host data moved in read");
  idle_out_a: assert property (host_enable_strobe_n[*6]
    |-> $stable(host_data_out)) else $error("host data moved idle");
  rd_stand_a: assert property (!avs_read && !$past(avs_read)
    |-> $stable(avs_readdata)) else $error("readdata moved");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == 5'h1C |-> avs_readdata == 32'h0) else $error("unmapped");
  irq_fall_a: assert property ($fell(irq) |->
    wrTaken_r) else $error("irq fell alone");
  cover property ($rose(irq));
  cover property (avs_write && !avs_waitrequest && avs_address == 5'h04);
  cover property ((!host_enable_strobe_n && host_rw)[*8]);
endmodule : hpsh_host_port_chk

bind hpsh_host_port hpsh_host_port_chk u_chk (.clk(clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq),
  .host_enable_strobe_n(host_enable_strobe_n), .host_rw(host_rw),
  .host_addr(host_addr), .host_data_in(host_data_in),
  .host_data_out(host_data_out), .host_data_oe(host_data_oe),
  .host_request_line(host_request_line));

// >>> verif/hpsh_host_model.sv
/*
 Behavioural external host processor driving the byte-wide port.
 Assumes the device clock as its pacing clock; strobe is active low.
*/
`timescale 1ns/1ps
module hpsh_host_model (
  input wire logic clk,
  output logic strobeN,
  output logic rw,
  output logic [2:0] addr,
  output logic [7:0] dout,
  input wire logic [7:0] din
);
  logic [7:0] rdData;
  logic rdValid;
  // Idle pins at time zero
  initial
  begin
    strobeN = 1'b1;
    rw = 1'b1;
    addr = 3'h0;
    dout = 8'hA5;
    rdData = 8'h00;
    rdValid = 1'b0;
  end
  // One strobe: long width, then released data inverted
  task automatic cycle(input logic r, input logic [2:0] a,
    input logic [7:0] d, input logic rep);
    @(posedge clk);
    rw <= r;
    addr <= a;
    dout <= d;
    strobeN <= 1'b0;
    repeat (8) @(posedge clk);
    rdData <= din;
    rdValid <= rep;
    strobeN <= 1'b1;
    dout <= ~d;
    @(posedge clk);
    rdValid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : cycle
endmodule : hpsh_host_model

// >>> verif/hpsh_host_port_bench.sv
/*
 Self-checking bench of the host port block with a host model.
 Assumes the checker is bound separately; expectations go in a queue.
*/
`timescale 1ns/1ps
module hpsh_host_port_bench;
  logic clk, arstN, avsRead, avsWrite, avsWait, irq, strobeN, hostRw;
  logic [4:0] avsAddress;
  logic [31:0] avsWd, avsRd, expQ[$], mskQ[$], w;
  logic [2:0] hostAddr;
  logic [7:0] hostDin, hostDout;
  logic [1:0] flagTab [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  integer error_cnt, checked, seed, i;
  hpsh_host_port DUT (.clk(clk), .arst_n(arstN), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWd),
    .avs_readdata(avsRd), .avs_waitrequest(avsWait), .irq(irq),
    .host_enable_strobe_n(strobeN), .host_rw(hostRw),
    .host_addr(hostAddr), .host_data_in(hostDin), .host_data_out(hostDout),
    .host_data_oe(), .host_request_line());
  hpsh_host_model host (.clk(clk), .strobeN(strobeN), .rw(hostRw),
    .addr(hostAddr), .dout(hostDin), .din(hostDout));
  // Clock at 125 MHz
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic close_out;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0 && expQ.size() == 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic take(input string n, input logic [31:0] s);
    logic [31:0] m;
    if (expQ.size() == 0)
      check(n, s, 32'hFFFF_FFFF);
    else
    begin
      m = mskQ.pop_front();
      check(n, s & m, expQ.pop_front() & m);
    end
  endtask : take
  // Avalon transfer held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    integer n;
    logic done;
    avsAddress <= a;
    avsWd <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    done = 1'b0;
    for (n = 0; n < 50 && !done; n++)
    begin
      @(posedge clk);
      done = (avsWait === 1'b0);
    end
    if (!done)
    begin
      error_cnt++;
      close_out();
    end
    else
    begin
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      @(posedge clk);
    end
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] e, m);
    expQ.push_back(e);
    mskQ.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic hrd(input logic [2:0] a, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    mskQ.push_back(32'hFF);
    host.cycle(1'b1, a, 8'h00, 1'b1);
  endtask : hrd
  // Result watcher pops the oldest note
  always @(posedge clk)
  begin
    if (avsRead && avsWait === 1'b0)
      take("avs", avsRd);
    if (host.rdValid === 1'b1)
      take("host", {24'h0, host.rdData});
  end
  // Main sequence
  initial
  begin
    seed = 46;
    error_cnt = 0;
    checked = 0;
    arstN <= 1'b0;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    avsAddress <= 5'h00;
    avsWd <= 32'h0;
    repeat (8) @(posedge clk);
    arstN <= 1'b1;
    @(posedge clk);
    rd(hpsh_pkg::OFS_HVEC, {25'h0, hpsh_pkg::HVEC_RST}, 32'h7F);
    rd(5'h1C, 32'h0, 32'hFFFF_FFFF);
    rd(hpsh_pkg::OFS_STAT, 32'h40, 32'hC7);
    hrd(hpsh_pkg::HA_STAT, 8'h70);
    w = $random(seed) & 32'hFF_FFFF;
    host.cycle(1'b0, hpsh_pkg::HA_BHI, w[23:16], 1'b0);
    host.cycle(1'b0, hpsh_pkg::HA_BMID, w[15:8], 1'b0);
    host.cycle(1'b0, hpsh_pkg::HA_BLO, w[7:0], 1'b0);
    host.cycle(1'b0, hpsh_pkg::HA_BLO, ~w[7:0], 1'b0);
    rd(hpsh_pkg::OFS_STAT, 32'h80, 32'hC7);
    check("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, hpsh_pkg::OFS_IRQMSK, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, hpsh_pkg::OFS_IRQST, 32'h7);
    check("irq", {31'h0, irq}, 32'h0);
    rd(hpsh_pkg::OFS_RXWORD, w, 32'hFF_FFFF);
    rd(hpsh_pkg::OFS_STAT, 32'h40, 32'hC7);
    w = $random(seed) & 32'hFF_FFFF;
    bus(1'b1, hpsh_pkg::OFS_TXWORD, w);
    bus(1'b1, hpsh_pkg::OFS_TXWORD, ~w);
    hrd(hpsh_pkg::HA_STAT, 8'h78);
    hrd(hpsh_pkg::HA_BHI, w[23:16]);
    hrd(hpsh_pkg::HA_BMID, w[15:8]);
    hrd(hpsh_pkg::HA_BLO, w[7:0]);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, hpsh_pkg::OFS_CTRL, {30'h0, flagTab[i]});
      host.cycle(1'b1, hpsh_pkg::HA_STAT, 8'h00, 1'b0);
      hrd(hpsh_pkg::HA_STAT, {6'h1C, flagTab[i]});
      host.cycle(1'b0, hpsh_pkg::HA_CTRL, {6'h00, flagTab[i]}, 1'b0);
      rd(hpsh_pkg::OFS_STAT, {26'h1, 4'h0, flagTab[i]}, 32'hC7);
      rd(hpsh_pkg::OFS_STAT, {26'h1, 4'h0, flagTab[i]}, 32'hC7);
    end
    bus(1'b1, hpsh_pkg::OFS_IRQST, 32'h7);
    bus(1'b1, hpsh_pkg::OFS_IRQMSK, 32'h2);
    host.cycle(1'b0, hpsh_pkg::HA_HVEC, 8'h2A, 1'b0);
    rd(hpsh_pkg::OFS_HVEC, 32'h2A, 32'h7F);
    host.cycle(1'b0, hpsh_pkg::HA_CTRL, 8'h80, 1'b0);
    rd(hpsh_pkg::OFS_STAT, 32'h44, 32'hC7);
    host.cycle(1'b0, hpsh_pkg::HA_HVEC, 8'h33, 1'b0);
    rd(hpsh_pkg::OFS_HVEC, 32'h2A, 32'h7F);
    host.cycle(1'b0, hpsh_pkg::HA_CTRL, 8'h00, 1'b0);
    rd(hpsh_pkg::OFS_STAT, 32'h40, 32'hC7);
    // Command raised again, then acknowledged by device software
    host.cycle(1'b0, hpsh_pkg::HA_CTRL, 8'h80, 1'b0);
    bus(1'b1, hpsh_pkg::OFS_CTRL, 32'h6);
    rd(hpsh_pkg::OFS_STAT, 32'h40, 32'hC7);
    rd(hpsh_pkg::OFS_IRQST, 32'h2, 32'h7);
    check("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, hpsh_pkg::OFS_IRQST, 32'h2);
    check("irq", {31'h0, irq}, 32'h0);
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : hpsh_host_port_bench
